//--- hdl/aic_acq_control.sv
`timescale 1ns/1ps
// Function
// - A soft convert strobe starts one conversion when no conversion is running.
// - A falling edge on ext_convert_n starts one conversion while acquisition is disabled, or active with external timing.
// - Each finished conversion writes its result into the result FIFO by itself, unless the result store is full.
// - Not-empty flag is set while at least one result is held.
// - A FIFO read pops one result and clears not-empty when none remain.
// - Reading an empty FIFO returns undefined data.
// - Not-empty sets about ten microseconds after a conversion starts.
// - Storing more than 512 results sets a sticky overflow flag.
// - A start while a conversion is still running sets a sticky overrun flag.
// - Acquisition clear resets overflow, overrun, done flag and empties the FIFO.
// - Counters reload at acquisition end so a later trigger restarts it.
// - Posttrigger counts after first trigger; pretrigger counts after second trigger.
// - Acquisition starts on the start strobe or an ext_trigger_n falling edge.
// - Continuous scanning repeats the sequence gaplessly until the sample count ends.
// - Sequence stepping only with both step enable and acquisition enable set.
// - With scan period enabled, each sequence waits for the scan counter's end.
// - Load strobe makes the window-written setup the active channel setting.
// - Setup memory keeps its contents across conversions.
// - With divide disabled, scanning steps to the next setup entry after each conversion from entry zero.
// - An entry with the end marker ends the sequence, which restarts at zero.
// - With divide enabled, entries step only on divider output falling edges.
// - Conversions stop when the sample counter reaches zero.
module aic_acq_control #(
    parameter int RESULT_DEPTH = aic_pkg::RESULT_DEPTH,
    parameter int SETUP_DEPTH  = aic_pkg::SETUP_DEPTH
) (
    // Clock and reset
    input  wire logic                            SYS_CLK_IN,
    input  wire logic                            SYS_RST_IN,
    // Host strobes
    input  wire logic                            SOFT_CONVERT_STROBE_IN,
    input  wire logic                            ACQ_START_STROBE_IN,
    input  wire logic                            ACQ_CLEAR_STROBE_IN,
    input  wire logic                            RESULT_READ_STROBE_IN,
    input  wire logic                            CHANNEL_SETUP_CLEAR_STROBE_IN,
    input  wire logic                            CHANNEL_SETUP_LOAD_STROBE_IN,
    input  wire logic                            CHANNEL_SETUP_WRITE_IN,
    input  wire logic [aic_pkg::SETUP_W-1:0]     CHANNEL_SETUP_WINDOW_IN,
    // Command bits
    input  wire logic                            ACQUISITION_ENABLE_IN,
    input  wire logic                            SEQUENCE_STEP_ENABLE_IN,
    input  wire logic                            SCAN_PERIOD_ENABLE_IN,
    input  wire logic                            SEQUENCE_DIVIDE_ENABLE_IN,
    input  wire logic                            PRETRIGGER_MODE_IN,
    input  wire logic                            INTERNAL_TIMING_IN,
    input  wire logic [aic_pkg::INTERVAL_W-1:0]  SAMPLE_INTERVAL_IN,
    input  wire logic [aic_pkg::INTERVAL_W-1:0]  SCAN_INTERVAL_IN,
    input  wire logic [aic_pkg::COUNT_W-1:0]     SAMPLE_COUNT_IN,
    // Connector pins
    input  wire logic                            EXT_CONVERT_N_IN,
    input  wire logic                            EXT_TRIGGER_N_IN,
    input  wire logic                            DIVIDER_COUNTER_OUTPUT_N_IN,
    // Converter
    input  wire logic [aic_pkg::DATA_W-1:0]      ADC_DATA_IN,
    output logic                                 ADC_START_OUT,
    output logic      [aic_pkg::SETUP_W-1:0]     ADC_CHANNEL_SETUP_OUT,
    // Status
    output logic      [aic_pkg::DATA_W-1:0]      RESULT_DATA_OUT,
    output logic                                 RESULT_FIFO_NOT_EMPTY_OUT,
    output logic                                 OVERFLOW_OUT,
    output logic                                 OVERRUN_OUT,
    output logic                                 ACQUISITION_DONE_FLAG_OUT,
    output logic                                 ACQUISITION_ACTIVE_OUT,
    output logic                                 CONVERTER_BUSY_OUT
);

    localparam int STORE_DEPTH = RESULT_DEPTH - aic_pkg::BUFFER_DEPTH;
    localparam int PTR_W       = $clog2(STORE_DEPTH);
    localparam int CNT_W       = $clog2(STORE_DEPTH + 1);
    localparam int SPTR_W      = $clog2(SETUP_DEPTH);
    localparam int CONV_W      = $clog2(aic_pkg::CONV_BUSY_CYCLES + 1);
    localparam int IW          = aic_pkg::INTERVAL_W;
    localparam int CW          = aic_pkg::COUNT_W;

    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] ptr);
        if (ptr == PTR_W'(STORE_DEPTH - 1)) begin
            return '0;
        end
        return ptr + 1'h1;
    endfunction : ptr_step

    function automatic logic falling(input logic prev, input logic now);
        return prev && !now;
    endfunction : falling

    // Pin synchronisers and edge detection.
    logic [2:0] pin_sync1;
    logic [2:0] pin_sync2;
    logic [2:0] pin_prev;
    logic [2:0] next_pin_sync1;
    logic [2:0] next_pin_sync2;
    logic [2:0] next_pin_prev;
    logic       conv_fall;
    logic       trig_fall;
    logic       div_fall;

    always_comb begin
        next_pin_sync1 = {DIVIDER_COUNTER_OUTPUT_N_IN, EXT_TRIGGER_N_IN, EXT_CONVERT_N_IN};
        next_pin_sync2 = pin_sync1;
        next_pin_prev  = pin_sync2;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            pin_sync1 <= aic_pkg::PIN_RESET;
            pin_sync2 <= aic_pkg::PIN_RESET;
            pin_prev  <= aic_pkg::PIN_RESET;
        end else begin
            pin_sync1 <= next_pin_sync1;
            pin_sync2 <= next_pin_sync2;
            pin_prev  <= next_pin_prev;
        end
    end

    assign conv_fall = falling(pin_prev[0], pin_sync2[0]);
    assign trig_fall = falling(pin_prev[1], pin_sync2[1]);
    assign div_fall  = falling(pin_prev[2], pin_sync2[2]);

    // Channel setup memory, active setting and sequence pointer.
    logic [aic_pkg::SETUP_W-1:0] setup_mem [SETUP_DEPTH];
    logic [SPTR_W-1:0]           setup_wr_ptr;
    logic [SPTR_W-1:0]           next_setup_wr_ptr;
    logic [aic_pkg::SETUP_W-1:0] active_setup;
    logic [aic_pkg::SETUP_W-1:0] next_active_setup;
    logic [SPTR_W-1:0]           seq_ptr;
    logic [SPTR_W-1:0]           next_seq_ptr;
    logic [aic_pkg::SETUP_W-1:0] next_adc_setup;
    logic                        seq_mode;
    logic                        seq_step;
    logic                        seq_wrap;

    assign seq_mode = SEQUENCE_STEP_ENABLE_IN && ACQUISITION_ENABLE_IN;
    assign seq_wrap = setup_mem[seq_ptr][aic_pkg::SEQ_END_BIT];

    always_comb begin
        next_setup_wr_ptr = setup_wr_ptr;
        next_active_setup = active_setup;
        next_seq_ptr      = seq_ptr;
        if (CHANNEL_SETUP_WRITE_IN) begin
            next_setup_wr_ptr = setup_wr_ptr + 1'h1;
        end
        if (seq_step) begin
            next_seq_ptr = seq_wrap ? '0 : seq_ptr + 1'h1;
        end
        if (CHANNEL_SETUP_LOAD_STROBE_IN) begin
            next_active_setup = setup_mem[0];
            next_seq_ptr      = '0;
        end
        if (CHANNEL_SETUP_CLEAR_STROBE_IN) begin
            next_setup_wr_ptr = '0;
            next_seq_ptr      = '0;
        end
        next_adc_setup = seq_mode ? setup_mem[next_seq_ptr] : next_active_setup;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            setup_wr_ptr          <= '0;
            active_setup          <= '0;
            seq_ptr               <= '0;
            ADC_CHANNEL_SETUP_OUT <= '0;
            for (int i = 0; i < SETUP_DEPTH; i++) begin
                setup_mem[i] <= '0;
            end
        end else begin
            setup_wr_ptr          <= next_setup_wr_ptr;
            active_setup          <= next_active_setup;
            seq_ptr               <= next_seq_ptr;
            ADC_CHANNEL_SETUP_OUT <= next_adc_setup;
            if (CHANNEL_SETUP_CLEAR_STROBE_IN) begin
                for (int i = 0; i < SETUP_DEPTH; i++) begin
                    setup_mem[i] <= '0;
                end
            end else if (CHANNEL_SETUP_WRITE_IN) begin
                setup_mem[setup_wr_ptr] <= CHANNEL_SETUP_WINDOW_IN;
            end
        end
    end

    // Acquisition sequencing and conversion timing.
    aic_pkg::aic_state_type state;
    aic_pkg::aic_state_type next_state;
    logic              counting;
    logic              next_counting;
    logic [CW-1:0]     sample_left;
    logic [CW-1:0]     next_sample_left;
    logic [IW-1:0]     interval_cnt;
    logic [IW-1:0]     next_interval_cnt;
    logic [IW-1:0]     scan_cnt;
    logic [IW-1:0]     next_scan_cnt;
    logic [CONV_W-1:0] conv_cnt;
    logic [CONV_W-1:0] next_conv_cnt;
    logic              next_start;
    logic              next_overrun;
    logic              next_overflow;
    logic              next_done;
    logic              conv_req;
    logic              conv_end;
    logic              busy;
    logic              sample_tick;
    logic              store_full;
    logic              push;

    assign busy        = conv_cnt != '0;
    assign conv_end    = conv_cnt == CONV_W'(1);
    assign sample_tick = INTERNAL_TIMING_IN && state == aic_pkg::ST_ACTIVE
                         && interval_cnt == IW'(1);
    assign seq_step    = seq_mode && (SEQUENCE_DIVIDE_ENABLE_IN ? div_fall : conv_end);

    always_comb begin
        next_state        = state;
        next_counting     = counting;
        next_sample_left  = sample_left;
        next_interval_cnt = interval_cnt;
        next_scan_cnt     = scan_cnt;
        next_conv_cnt     = conv_cnt;
        next_overrun      = OVERRUN_OUT;
        next_overflow     = OVERFLOW_OUT;
        next_done         = ACQUISITION_DONE_FLAG_OUT;
        conv_req = SOFT_CONVERT_STROBE_IN;
        if (!ACQUISITION_ENABLE_IN) begin
            conv_req = conv_req || conv_fall;
        end else if (state == aic_pkg::ST_ACTIVE) begin
            conv_req = conv_req || (INTERNAL_TIMING_IN ? sample_tick : conv_fall);
        end
        next_start = conv_req && !busy;
        if (busy) begin
            next_conv_cnt = conv_cnt - 1'h1;
        end
        if (next_start) begin
            next_conv_cnt = CONV_W'(aic_pkg::CONV_BUSY_CYCLES);
        end
        if (state == aic_pkg::ST_ACTIVE && INTERNAL_TIMING_IN) begin
            next_interval_cnt = sample_tick ? SAMPLE_INTERVAL_IN : interval_cnt - 1'h1;
        end
        if (state != aic_pkg::ST_IDLE && scan_cnt != '0) begin
            next_scan_cnt = scan_cnt - 1'h1;
        end
        case (state)
            aic_pkg::ST_IDLE: begin
                if (ACQUISITION_ENABLE_IN && (ACQ_START_STROBE_IN || trig_fall)) begin
                    next_state        = aic_pkg::ST_ACTIVE;
                    next_counting     = !PRETRIGGER_MODE_IN;
                    next_sample_left  = SAMPLE_COUNT_IN;
                    next_interval_cnt = SAMPLE_INTERVAL_IN;
                    next_scan_cnt     = SCAN_INTERVAL_IN;
                end
            end
            aic_pkg::ST_ACTIVE: begin
                if (!counting && (ACQ_START_STROBE_IN || trig_fall)) begin
                    next_counting = 1'h1;
                end
                if (seq_step && seq_wrap && SCAN_PERIOD_ENABLE_IN) begin
                    if (scan_cnt > IW'(1)) begin
                        next_state = aic_pkg::ST_SCAN_WAIT;
                    end else begin
                        next_scan_cnt = SCAN_INTERVAL_IN;
                    end
                end
                if (counting && next_start) begin
                    next_sample_left = sample_left - 1'h1;
                    if (sample_left == CW'(1)) begin
                        next_state        = aic_pkg::ST_IDLE;
                        next_counting     = 1'h0;
                        next_done         = 1'h1;
                        next_sample_left  = SAMPLE_COUNT_IN;
                        next_interval_cnt = SAMPLE_INTERVAL_IN;
                        next_scan_cnt     = SCAN_INTERVAL_IN;
                    end
                end
                if (!ACQUISITION_ENABLE_IN) begin
                    next_state    = aic_pkg::ST_IDLE;
                    next_counting = 1'h0;
                end
            end
            aic_pkg::ST_SCAN_WAIT: begin
                if (!counting && (ACQ_START_STROBE_IN || trig_fall)) begin
                    next_counting = 1'h1;
                end
                if (scan_cnt <= IW'(1)) begin
                    next_state        = aic_pkg::ST_ACTIVE;
                    next_scan_cnt     = SCAN_INTERVAL_IN;
                    next_interval_cnt = SAMPLE_INTERVAL_IN;
                end
                if (!ACQUISITION_ENABLE_IN) begin
                    next_state    = aic_pkg::ST_IDLE;
                    next_counting = 1'h0;
                end
            end
            default: begin
                next_state = aic_pkg::ST_IDLE;
            end
        endcase
        if (ACQ_CLEAR_STROBE_IN) begin
            next_overrun  = 1'h0;
            next_overflow = 1'h0;
            next_done     = 1'h0;
        end
        if (conv_req && busy) begin
            next_overrun = 1'h1;
        end
        if (conv_end && store_full) begin
            next_overflow = 1'h1;
        end
        if (state == aic_pkg::ST_ACTIVE && counting && next_state == aic_pkg::ST_IDLE
            && sample_left == CW'(1)) begin
            next_done = 1'h1;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            state                     <= aic_pkg::ST_IDLE;
            counting                  <= 1'h0;
            sample_left               <= '0;
            interval_cnt              <= '0;
            scan_cnt                  <= '0;
            conv_cnt                  <= '0;
            ADC_START_OUT             <= 1'h0;
            OVERRUN_OUT               <= aic_pkg::FLAG_RESET;
            OVERFLOW_OUT              <= aic_pkg::FLAG_RESET;
            ACQUISITION_DONE_FLAG_OUT <= aic_pkg::FLAG_RESET;
            ACQUISITION_ACTIVE_OUT    <= 1'h0;
            CONVERTER_BUSY_OUT        <= 1'h0;
        end else begin
            state                     <= next_state;
            counting                  <= next_counting;
            sample_left               <= next_sample_left;
            interval_cnt              <= next_interval_cnt;
            scan_cnt                  <= next_scan_cnt;
            conv_cnt                  <= next_conv_cnt;
            ADC_START_OUT             <= next_start;
            OVERRUN_OUT               <= next_overrun;
            OVERFLOW_OUT              <= next_overflow;
            ACQUISITION_DONE_FLAG_OUT <= next_done;
            ACQUISITION_ACTIVE_OUT    <= next_state != aic_pkg::ST_IDLE;
            CONVERTER_BUSY_OUT        <= next_conv_cnt != '0;
        end
    end

    // Result storage in front of the two-entry output buffer.
    logic [aic_pkg::DATA_W-1:0] store_mem [STORE_DEPTH];
    logic [PTR_W-1:0]           store_wr;
    logic [PTR_W-1:0]           store_rd;
    logic [CNT_W-1:0]           store_cnt;
    logic [PTR_W-1:0]           next_store_wr;
    logic [PTR_W-1:0]           next_store_rd;
    logic [CNT_W-1:0]           next_store_cnt;
    logic                       buf_ready;
    logic                       drain;

    assign store_full = store_cnt == CNT_W'(STORE_DEPTH);
    assign push       = conv_end && !store_full;
    assign drain      = store_cnt != '0 && buf_ready;

    always_comb begin
        next_store_wr  = store_wr;
        next_store_rd  = store_rd;
        next_store_cnt = store_cnt;
        if (ACQ_CLEAR_STROBE_IN) begin
            next_store_rd  = store_wr;
            next_store_cnt = '0;
        end else if (drain) begin
            next_store_rd  = ptr_step(store_rd);
            next_store_cnt = next_store_cnt - 1'h1;
        end
        if (push) begin
            next_store_wr  = ptr_step(store_wr);
            next_store_cnt = next_store_cnt + 1'h1;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            store_wr  <= '0;
            store_rd  <= '0;
            store_cnt <= '0;
        end else begin
            store_wr  <= next_store_wr;
            store_rd  <= next_store_rd;
            store_cnt <= next_store_cnt;
            if (push) begin
                store_mem[store_wr] <= ADC_DATA_IN;
            end
        end
    end

    // not-empty flag, read pops, empty read ignored
    aic_skid_buffer #(
        .WIDTH(aic_pkg::DATA_W)
    ) u_out_buffer (
        .clk_in       (SYS_CLK_IN),
        .rst_in       (SYS_RST_IN),
        .flush_in     (ACQ_CLEAR_STROBE_IN),
        .in_valid_in  (drain && !ACQ_CLEAR_STROBE_IN),
        .in_data_in   (store_mem[store_rd]),
        .in_ready_out (buf_ready),
        .out_valid_out(RESULT_FIFO_NOT_EMPTY_OUT),
        .out_data_out (RESULT_DATA_OUT),
        .out_ready_in (RESULT_READ_STROBE_IN)
    );

endmodule : aic_acq_control

//--- hdl/aic_skid_buffer.sv
`timescale 1ns/1ps
module aic_skid_buffer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             flush_in,
    // Filling side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Draining side
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);

    logic             head_valid;
    logic [WIDTH-1:0] head_data;
    logic             skid_valid;
    logic [WIDTH-1:0] skid_data;
    logic             next_head_valid;
    logic [WIDTH-1:0] next_head_data;
    logic             next_skid_valid;
    logic [WIDTH-1:0] next_skid_data;

    // The head entry is popped first, then an incoming word fills the first free slot.
    always_comb begin
        next_head_valid = head_valid;
        next_head_data  = head_data;
        next_skid_valid = skid_valid;
        next_skid_data  = skid_data;
        if (out_ready_in && head_valid) begin
            next_head_valid = skid_valid;
            next_head_data  = skid_data;
            next_skid_valid = 1'h0;
        end
        if (in_valid_in && !skid_valid) begin
            if (!next_head_valid) begin
                next_head_valid = 1'h1;
                next_head_data  = in_data_in;
            end else begin
                next_skid_valid = 1'h1;
                next_skid_data  = in_data_in;
            end
        end
        if (flush_in) begin
            next_head_valid = 1'h0;
            next_skid_valid = 1'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            head_valid <= 1'h0;
            head_data  <= '0;
            skid_valid <= 1'h0;
            skid_data  <= '0;
        end else begin
            head_valid <= next_head_valid;
            head_data  <= next_head_data;
            skid_valid <= next_skid_valid;
            skid_data  <= next_skid_data;
        end
    end

    assign in_ready_out  = !skid_valid;
    assign out_valid_out = head_valid;
    assign out_data_out  = head_data;

endmodule : aic_skid_buffer

//--- pkg/aic_pkg.sv
package aic_pkg;

    // Clock and conversion timing.
    localparam int CLK_PERIOD_NS    = 8;
    localparam int CONV_TIME_US     = 10;
    localparam int CONV_CYCLES      = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int RESULT_FLAG_LAT  = 3;
    localparam int CONV_BUSY_CYCLES = CONV_CYCLES - RESULT_FLAG_LAT;

    // Result path sizes.
    localparam int DATA_W       = 16;
    localparam int RESULT_DEPTH = 512;
    localparam int BUFFER_DEPTH = 2;

    // Channel setup memory layout.
    localparam int SETUP_W       = 16;
    localparam int SETUP_DEPTH   = 16;
    localparam int SEQ_END_BIT   = 15;

    // Counter widths.
    localparam int COUNT_W    = 17;
    localparam int INTERVAL_W = 16;

    // Reset values.
    localparam logic       FLAG_RESET = 1'h0;
    localparam logic [2:0] PIN_RESET  = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_SCAN_WAIT
    } aic_state_type;

endpackage : aic_pkg

//--- verif/aic_acq_control_sva.sv
`timescale 1ns/1ps
module aic_acq_control_sva (
    // Watched ports
    input wire logic SYS_CLK_IN, SYS_RST_IN, SOFT_CONVERT_STROBE_IN, ACQ_CLEAR_STROBE_IN,
    input wire logic RESULT_READ_STROBE_IN, ADC_START_OUT, CONVERTER_BUSY_OUT, OVERRUN_OUT,
    input wire logic RESULT_FIFO_NOT_EMPTY_OUT, OVERFLOW_OUT, ACQUISITION_ACTIVE_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    soft_start_a: assert property (SOFT_CONVERT_STROBE_IN && !CONVERTER_BUSY_OUT |=>
        ADC_START_OUT) else $error("no start");
    start_once_a: assert property (ADC_START_OUT |=> !ADC_START_OUT [*8])
        else $error("start repeated");
    refuse_busy_a: assert property (SOFT_CONVERT_STROBE_IN && CONVERTER_BUSY_OUT |=>
        OVERRUN_OUT && !ADC_START_OUT) else $error("start while busy");
    logic [10:0] fill_wait;
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            fill_wait <= 11'h000;
        end else if (ADC_START_OUT) begin
            fill_wait <= 11'h001;
        end else if (RESULT_FIFO_NOT_EMPTY_OUT) begin
            fill_wait <= 11'h000;
        end else if (fill_wait != 11'h000) begin
            fill_wait <= fill_wait + 11'h001;
        end
    end
    fill_time_a: assert property (fill_wait <= 11'h4E1)
        else $error("result late");
    ovr_sticky_a: assert property (OVERRUN_OUT && !ACQ_CLEAR_STROBE_IN |=> OVERRUN_OUT)
        else $error("overrun lost");
    ovf_sticky_a: assert property (OVERFLOW_OUT && !ACQ_CLEAR_STROBE_IN |=> OVERFLOW_OUT)
        else $error("overflow lost");
    clear_all_a: assert property (ACQ_CLEAR_STROBE_IN && !CONVERTER_BUSY_OUT &&
        !$past(CONVERTER_BUSY_OUT) && !ACQUISITION_ACTIVE_OUT && !SOFT_CONVERT_STROBE_IN
        |=> !OVERRUN_OUT && !OVERFLOW_OUT && !RESULT_FIFO_NOT_EMPTY_OUT) else $error("no clear");
    fill_cause_a: assert property ($rose(RESULT_FIFO_NOT_EMPTY_OUT) |->
        $past(CONVERTER_BUSY_OUT, 3) || $past(CONVERTER_BUSY_OUT, 4)) else $error("stray fill");
    cover property (OVERRUN_OUT);
    cover property (OVERFLOW_OUT);
    cover property (RESULT_READ_STROBE_IN && RESULT_FIFO_NOT_EMPTY_OUT);
endmodule : aic_acq_control_sva
bind aic_acq_control aic_acq_control_sva i_sva (.*);

//--- verif/aic_acq_control_tb.sv
`timescale 1ns/1ps
module aic_acq_control_tb;
    logic SYS_CLK_IN = 1'b0, SYS_RST_IN = 1'b1, ACQUISITION_ENABLE_IN = 1'b0;
    logic SEQUENCE_STEP_ENABLE_IN = 1'b0, SCAN_PERIOD_ENABLE_IN = 1'b0, INTERNAL_TIMING_IN = 1'b1;
    logic SEQUENCE_DIVIDE_ENABLE_IN = 1'b0, PRETRIGGER_MODE_IN = 1'b0, EXT_CONVERT_N_IN = 1'b1;
    logic EXT_TRIGGER_N_IN = 1'b1, DIVIDER_COUNTER_OUTPUT_N_IN = 1'b1, ADC_START_OUT, OVERRUN_OUT;
    logic RESULT_FIFO_NOT_EMPTY_OUT, OVERFLOW_OUT, ACQUISITION_DONE_FLAG_OUT, CONVERTER_BUSY_OUT;
    logic ACQUISITION_ACTIVE_OUT;
    logic [6:0] stb = 7'h00;
    logic [15:0] CHANNEL_SETUP_WINDOW_IN = 16'h0000, SAMPLE_INTERVAL_IN = 16'h0578, w = 16'h0000;
    logic [15:0] SCAN_INTERVAL_IN = 16'h0000, ADC_DATA_IN, ADC_CHANNEL_SETUP_OUT, RESULT_DATA_OUT;
    logic [16:0] SAMPLE_COUNT_IN = 17'h0_0002;
    logic [15:0] exp_q[$];
    int n_mismatch = 0, total_checks = 0;
    aic_acq_control #(.RESULT_DEPTH(8)) i_dut (.*, .SOFT_CONVERT_STROBE_IN(stb[0]),
        .ACQ_START_STROBE_IN(stb[1]), .ACQ_CLEAR_STROBE_IN(stb[2]), .RESULT_READ_STROBE_IN(stb[3]),
        .CHANNEL_SETUP_CLEAR_STROBE_IN(stb[4]), .CHANNEL_SETUP_LOAD_STROBE_IN(stb[5]),
        .CHANNEL_SETUP_WRITE_IN(stb[6]));
    aic_adc_model i_adc (.clk_in(SYS_CLK_IN), .start_in(ADC_START_OUT), .word_in(w),
        .data_out(ADC_DATA_IN));
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic pulse(input int b);
        stb[b] <= 1'b1;
        @(posedge SYS_CLK_IN);
        stb[b] <= 1'b0;
    endtask : pulse
    task automatic convert(input bit keep, input int how);
        logic [15:0] v;
        v = 16'($urandom);
        w <= v;
        if (keep) exp_q.push_back(v);
        if (how == 1) begin
            EXT_CONVERT_N_IN <= 1'b0;
            repeat (2) @(posedge SYS_CLK_IN);
            EXT_CONVERT_N_IN <= 1'b1;
        end else begin
            pulse(0);
        end
        repeat (9) @(posedge SYS_CLK_IN);
        if (how == 2) pulse(0);
        repeat (1260) @(posedge SYS_CLK_IN);
    endtask : convert
    task automatic drain();
        while (RESULT_FIFO_NOT_EMPTY_OUT === 1'b1) begin
            stb[3] <= 1'b1;
            @(posedge SYS_CLK_IN);
        end
        stb[3] <= 1'b0;
        @(posedge SYS_CLK_IN);
        check("left", 16'h0000, 16'(exp_q.size()));
    endtask : drain
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        forever #4 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    always @(posedge SYS_CLK_IN) begin
        if (stb[3] && RESULT_FIFO_NOT_EMPTY_OUT === 1'b1) begin
            check("result", exp_q.size() ? exp_q.pop_front() : 16'hxxxx, RESULT_DATA_OUT);
        end
    end
    initial begin
        repeat (40000) @(posedge SYS_CLK_IN);
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(32'h379a_f8e9));
        repeat (4) @(posedge SYS_CLK_IN);
        SYS_RST_IN <= 1'b0;
        pulse(4);
        CHANNEL_SETUP_WINDOW_IN <= 16'($urandom);
        pulse(6);
        pulse(5);
        repeat (2) @(posedge SYS_CLK_IN);
        check("setup", CHANNEL_SETUP_WINDOW_IN, ADC_CHANNEL_SETUP_OUT);
        for (int i = 0; i < 9; i++) convert(i < 8, 0);
        check("setup", CHANNEL_SETUP_WINDOW_IN, ADC_CHANNEL_SETUP_OUT);
        drain();
        convert(1'b1, 2);
        check("errors", 16'h0003, {14'h0000, OVERRUN_OUT, OVERFLOW_OUT});
        pulse(2);
        exp_q.delete();
        @(posedge SYS_CLK_IN);
        check("flags", 16'h0000, {13'h0, OVERRUN_OUT, OVERFLOW_OUT, RESULT_FIFO_NOT_EMPTY_OUT});
        convert(1'b1, 1);
        drain();
        ACQUISITION_ENABLE_IN <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                pulse(4);
                for (int j = 0; j < 2; j++) begin
                    CHANNEL_SETUP_WINDOW_IN <= {j[0], 15'($urandom)};
                    pulse(6);
                    @(posedge SYS_CLK_IN);
                end
                pulse(5);
                PRETRIGGER_MODE_IN <= 1'b1;
                SEQUENCE_STEP_ENABLE_IN <= 1'b1;
            end
            pulse(2);
            w <= 16'($urandom);
            @(posedge SYS_CLK_IN);
            repeat (2 + k[1]) exp_q.push_back(w);
            if (k != 1) pulse(1);
            else begin
                EXT_TRIGGER_N_IN <= 1'b0;
                repeat (3) @(posedge SYS_CLK_IN);
                EXT_TRIGGER_N_IN <= 1'b1;
            end
            if (k == 2) begin
                repeat (1500) @(posedge SYS_CLK_IN);
                pulse(1);
            end
            repeat (4300) @(posedge SYS_CLK_IN);
            check("done", 16'h0001, 16'(ACQUISITION_DONE_FLAG_OUT));
            check("active", 16'h0000, 16'(ACQUISITION_ACTIVE_OUT));
            if (k == 2) check("seq", CHANNEL_SETUP_WINDOW_IN, ADC_CHANNEL_SETUP_OUT);
            drain();
        end
        close_out();
    end
endmodule : aic_acq_control_tb

//--- verif/aic_adc_model.sv
`timescale 1ns/1ps
module aic_adc_model (
    // Converter control
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic [15:0] word_in,
    // Converter result
    output logic      [15:0] data_out
);
    initial data_out = 16'h0000;
    always @(posedge clk_in) begin
        if (start_in) data_out <= word_in;
    end
endmodule : aic_adc_model
